// ==== inc/stop_clock_pkg.sv ====
// constants, register indices and bit positions for the stop/clock-protect block
// assumes a simple strobe register port, byte-wide registers in the low bits
package stop_clock_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // register indices (own map)
    localparam logic [3:0] CLOCK_CONTROL_REG_A_IDX         = 4'h0;
    localparam logic [3:0] CLOCK_CONTROL_REG_B_IDX         = 4'h1;
    localparam logic [3:0] PERIPHERAL_CLOCK_SELECT_REG_IDX = 4'h2;
    localparam logic [3:0] PROCESSOR_MODE_REG_A_IDX        = 4'h3;
    localparam logic [3:0] PROCESSOR_MODE_REG_B_IDX        = 4'h4;
    localparam logic [3:0] PROCESSOR_MODE_REG_C_IDX        = 4'h5;
    localparam logic [3:0] WRITE_PROTECT_REG_IDX           = 4'h6;
    localparam logic [3:0] PORT9_DIRECTION_REG_IDX         = 4'h7;
    localparam logic [3:0] SERIAL3_CONTROL_REG_IDX         = 4'h8;
    localparam logic [3:0] SERIAL4_CONTROL_REG_IDX         = 4'h9;
    localparam logic [3:0] STATUS_REG_IDX                  = 4'hA;

    // clock_control_reg_a bits
    localparam int unsigned WAIT_PERIPH_CLOCK_STOP_POS  = 2;
    localparam int unsigned MAIN_OSC_STOP_BIT_POS       = 5;
    localparam int unsigned DIVIDE_BY_EIGHT_SELECT_POS  = 6;
    localparam int unsigned CPU_CLOCK_SOURCE_SELECT_POS = 7;
    // clock_out select field, bits 1:0: 0 port, 1 fc, 2 f8, 3 f32
    localparam logic [1:0]  CLOCK_OUTPUT_PIN_SEL_FC  = 2'h1;
    // clock_control_reg_b bits
    localparam int unsigned STOP_ALL_CLOCKS_BIT_POS = 0;
    localparam int unsigned MAIN_DIVIDER_BIT_POS    = 1;
    localparam int unsigned MAIN_OSC_DRIVE_HIGH_POS = 5;
    // processor_mode_reg_c bit
    localparam int unsigned CLOCK_CHANGE_LOCK_POS = 1;
    // write_protect_reg bits
    localparam int unsigned CLOCK_REGS_WRITE_ENABLE_POS  = 0;
    localparam int unsigned MODE_REGS_WRITE_ENABLE_POS   = 1;
    localparam int unsigned PORT_SERIAL_WRITE_ENABLE_POS = 2;
    // processor_mode_reg_a bits 1:0 select memory expansion
    localparam logic [1:0] SINGLE_CHIP_MODE = 2'h0;

    // reset values
    localparam logic [7:0] CLOCK_CONTROL_REG_A_RST = 8'h48;
    localparam logic [7:0] CLOCK_CONTROL_REG_B_RST = 8'h20;
    localparam logic [7:0] ZERO_RST                = 8'h00;

    // mask of protected bits under clock_change_lock
    localparam logic [7:0] LOCK_MASK_A = 8'hA4;
    localparam logic [7:0] LOCK_MASK_B = 8'h03;

    // clocks restart delay after wake, in cycles
    localparam logic [3:0] WAKE_SETTLE_CYCLES = 4'h8;
endpackage : stop_clock_pkg

// ==== design/stop_mode_clock_protect.sv ====
// stop mode, clock-change lock and write-protect logic of the clock controller
// assumes cpu register port on core_clk; wake sources arrive as synchronous levels
//
// Summary of operation
// - stop mode gates main and sub oscillators and internal clocks
// - externally clocked peripherals keep running while stopped
// - nmi, key, int, timer-event, external-clock serial wake
// - expansion oscillator stops only when all three low
// - writing one to stop bit enters stop
// - entering stop sets divide-by-eight and high drive
// - reset, nmi or enabled peripheral request exits stop
// - wake restarts cpu clock then runs handler
// - wake resumes sub clock or main divided eight
// - outside single-chip mode, stopped bus pins hold; strobes driven high
// - single-chip clock out high for fc, else hold
// - lock bit blocks writes to clock bits
// - three enables protect clock, mode, port/serial registers
// - port/serial enable clears after any next write to another register
// - clock and mode enables cleared only by software
module stop_mode_clock_protect (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        nmi_req,
    input  wire logic        key_int_req,
    input  wire logic        ext_pin_int_req,
    input  wire logic        timer_event_int_req,
    input  wire logic        serial_ext_clk_int_req,
    input  wire logic        periph_int_enabled,
    input  wire logic        expansion_crystal_osc_on,
    input  wire logic        expansion_osc_on_b,
    input  wire logic        expansion_osc_on_c,
    input  wire logic        clock_output_pin_div_in,
    output logic             main_osc_enable,
    output logic             sub_osc_enable,
    output logic             expansion_osc_enable,
    output logic             cpu_clock_enable,
    output logic             periph_clock_enable,
    output logic             ext_periph_clock_enable,
    output logic             cpu_on_sub_clock,
    output logic             cpu_main_div8,
    output logic             wake_irq,
    output logic             stopped,
    output logic             bus_hold_levels,
    output logic             bus_strobes_high,
    output logic             clock_output_pin,
    output logic [7:0]       port9_direction,
    output logic [7:0]       serial3_control,
    output logic [7:0]       serial4_control,
    output logic [7:0]       peripheral_clock_select
);
    typedef enum logic [1:0] {RUN, STOP, WAKE} pwr_state_t;

    pwr_state_t  state_reg;
    logic [7:0]  clock_control_reg_a;
    logic [7:0]  clock_control_reg_b;
    logic [7:0]  peripheral_clock_select_reg;
    logic [7:0]  processor_mode_reg_a;
    logic [7:0]  processor_mode_reg_b;
    logic [7:0]  processor_mode_reg_c;
    logic [7:0]  write_protect_reg;
    logic [7:0]  port9_direction_reg;
    logic [7:0]  serial3_control_reg;
    logic [7:0]  serial4_control_reg;
    logic [3:0]  settle_reg;
    logic        sub_before_stop_reg;
    logic        clock_output_pin_reg;
    logic        wake_irq_reg;
    logic [7:0]  rdata_reg;

    logic        clock_we;
    logic        mode_we;
    logic        port_we;
    logic        locked;
    logic        wake_src;
    logic        stop_write;

    // masked merge: bits in mask keep their old value
    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] keep);
        merge = (old_v & keep) | (new_v & ~keep);
    endfunction : merge

    function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
        hit = reg_wr && (a == idx);
    endfunction : hit

    assign clock_we = write_protect_reg[stop_clock_pkg::CLOCK_REGS_WRITE_ENABLE_POS];
    assign mode_we  = write_protect_reg[stop_clock_pkg::MODE_REGS_WRITE_ENABLE_POS];
    assign port_we  = write_protect_reg[stop_clock_pkg::PORT_SERIAL_WRITE_ENABLE_POS];
    assign locked   = processor_mode_reg_c[stop_clock_pkg::CLOCK_CHANGE_LOCK_POS];

    // only externally clocked sources can fire while oscillators are off
    assign wake_src = nmi_req || key_int_req || ext_pin_int_req
                      || ((timer_event_int_req || serial_ext_clk_int_req) && periph_int_enabled);

    assign stop_write = hit(reg_addr, stop_clock_pkg::CLOCK_CONTROL_REG_B_IDX) && clock_we && !locked
                        && reg_wdata[stop_clock_pkg::STOP_ALL_CLOCKS_BIT_POS];

    // power state
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg  <= RUN;
            settle_reg <= 4'h0;
        end
        else
        begin
            case (state_reg)
                RUN:
                begin
                    if (stop_write)
                    begin
                        state_reg <= STOP;
                    end
                end
                STOP:
                begin
                    if (wake_src)
                    begin
                        state_reg  <= WAKE;
                        settle_reg <= stop_clock_pkg::WAKE_SETTLE_CYCLES;
                    end
                end
                WAKE:
                begin
                    // clock restarts first, handler request follows settle
                    if (settle_reg == 4'h1)
                    begin
                        state_reg <= RUN;
                    end
                    settle_reg <= settle_reg - 4'h1;
                end
                default:
                begin
                    state_reg <= RUN;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wake_irq_reg <= 1'b0;
        end
        else
        begin
            wake_irq_reg <= (state_reg == WAKE) && (settle_reg == 4'h1);
        end
    end

    // remember clock source at stop entry
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sub_before_stop_reg <= 1'b0;
        end
        else if (state_reg == RUN && stop_write)
        begin
            sub_before_stop_reg <= clock_control_reg_a[stop_clock_pkg::CPU_CLOCK_SOURCE_SELECT_POS];
        end
    end

    // clock control registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            clock_control_reg_a <= stop_clock_pkg::CLOCK_CONTROL_REG_A_RST;
            clock_control_reg_b <= stop_clock_pkg::CLOCK_CONTROL_REG_B_RST;
        end
        else
        begin
            if (hit(reg_addr, stop_clock_pkg::CLOCK_CONTROL_REG_A_IDX) && clock_we)
            begin
                clock_control_reg_a <= merge(clock_control_reg_a, reg_wdata,
                                             locked ? stop_clock_pkg::LOCK_MASK_A : 8'h00);
            end
            if (hit(reg_addr, stop_clock_pkg::CLOCK_CONTROL_REG_B_IDX) && clock_we)
            begin
                clock_control_reg_b <= merge(clock_control_reg_b, reg_wdata,
                                             locked ? stop_clock_pkg::LOCK_MASK_B : 8'h00);
            end
            if (state_reg == RUN && stop_write)
            begin
                clock_control_reg_a[stop_clock_pkg::DIVIDE_BY_EIGHT_SELECT_POS] <= 1'b1;
                clock_control_reg_b[stop_clock_pkg::MAIN_OSC_DRIVE_HIGH_POS]    <= 1'b1;
            end
            if (state_reg == WAKE && settle_reg == 4'h1)
            begin
                clock_control_reg_b[stop_clock_pkg::STOP_ALL_CLOCKS_BIT_POS] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            peripheral_clock_select_reg <= stop_clock_pkg::ZERO_RST;
        end
        else if (hit(reg_addr, stop_clock_pkg::PERIPHERAL_CLOCK_SELECT_REG_IDX) && clock_we)
        begin
            peripheral_clock_select_reg <= reg_wdata;
        end
    end

    // processor mode registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            processor_mode_reg_a <= stop_clock_pkg::ZERO_RST;
            processor_mode_reg_b <= stop_clock_pkg::ZERO_RST;
            processor_mode_reg_c <= stop_clock_pkg::ZERO_RST;
        end
        else if (mode_we)
        begin
            if (hit(reg_addr, stop_clock_pkg::PROCESSOR_MODE_REG_A_IDX))
            begin
                processor_mode_reg_a <= reg_wdata;
            end
            if (hit(reg_addr, stop_clock_pkg::PROCESSOR_MODE_REG_B_IDX))
            begin
                processor_mode_reg_b <= reg_wdata;
            end
            if (hit(reg_addr, stop_clock_pkg::PROCESSOR_MODE_REG_C_IDX))
            begin
                processor_mode_reg_c <= reg_wdata;
            end
        end
    end

    // protect register; port/serial enable self-clears on any later write to another address
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            write_protect_reg <= stop_clock_pkg::ZERO_RST;
        end
        else if (reg_wr)
        begin
            if (reg_addr == stop_clock_pkg::WRITE_PROTECT_REG_IDX)
            begin
                write_protect_reg <= reg_wdata;
            end
            else
            begin
                write_protect_reg[stop_clock_pkg::PORT_SERIAL_WRITE_ENABLE_POS] <= 1'b0;
            end
        end
    end

    // port and serial registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            port9_direction_reg <= stop_clock_pkg::ZERO_RST;
            serial3_control_reg <= stop_clock_pkg::ZERO_RST;
            serial4_control_reg <= stop_clock_pkg::ZERO_RST;
        end
        else if (port_we)
        begin
            if (hit(reg_addr, stop_clock_pkg::PORT9_DIRECTION_REG_IDX))
            begin
                port9_direction_reg <= reg_wdata;
            end
            if (hit(reg_addr, stop_clock_pkg::SERIAL3_CONTROL_REG_IDX))
            begin
                serial3_control_reg <= reg_wdata;
            end
            if (hit(reg_addr, stop_clock_pkg::SERIAL4_CONTROL_REG_IDX))
            begin
                serial4_control_reg <= reg_wdata;
            end
        end
    end

    // clock output pin: frozen or high while stopped
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            clock_output_pin_reg <= 1'b0;
        end
        else if (state_reg == STOP)
        begin
            if (clock_control_reg_a[1:0] == stop_clock_pkg::CLOCK_OUTPUT_PIN_SEL_FC)
            begin
                clock_output_pin_reg <= 1'b1;
            end
        end
        else
        begin
            clock_output_pin_reg <= clock_output_pin_div_in;
        end
    end

    // read port
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rdata_reg <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == stop_clock_pkg::CLOCK_CONTROL_REG_A_IDX)
                rdata_reg <= clock_control_reg_a;
            else if (reg_addr == stop_clock_pkg::CLOCK_CONTROL_REG_B_IDX)
                rdata_reg <= clock_control_reg_b;
            else if (reg_addr == stop_clock_pkg::PERIPHERAL_CLOCK_SELECT_REG_IDX)
                rdata_reg <= peripheral_clock_select_reg;
            else if (reg_addr == stop_clock_pkg::PROCESSOR_MODE_REG_A_IDX)
                rdata_reg <= processor_mode_reg_a;
            else if (reg_addr == stop_clock_pkg::PROCESSOR_MODE_REG_B_IDX)
                rdata_reg <= processor_mode_reg_b;
            else if (reg_addr == stop_clock_pkg::PROCESSOR_MODE_REG_C_IDX)
                rdata_reg <= processor_mode_reg_c;
            else if (reg_addr == stop_clock_pkg::WRITE_PROTECT_REG_IDX)
                rdata_reg <= write_protect_reg;
            else if (reg_addr == stop_clock_pkg::PORT9_DIRECTION_REG_IDX)
                rdata_reg <= port9_direction_reg;
            else if (reg_addr == stop_clock_pkg::SERIAL3_CONTROL_REG_IDX)
                rdata_reg <= serial3_control_reg;
            else if (reg_addr == stop_clock_pkg::SERIAL4_CONTROL_REG_IDX)
                rdata_reg <= serial4_control_reg;
            else if (reg_addr == stop_clock_pkg::STATUS_REG_IDX)
                rdata_reg <= {6'h00, state_reg};
            else
                rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

    assign stopped                 = (state_reg == STOP);
    assign main_osc_enable         = !stopped && !clock_control_reg_a[stop_clock_pkg::MAIN_OSC_STOP_BIT_POS];
    assign sub_osc_enable          = !stopped;
    assign cpu_clock_enable        = (state_reg == RUN);
    assign periph_clock_enable     = (state_reg == RUN);
    assign ext_periph_clock_enable = 1'b1;
    assign expansion_osc_enable    = !stopped || expansion_crystal_osc_on
                                     || expansion_osc_on_b || expansion_osc_on_c;
    assign cpu_on_sub_clock        = clock_control_reg_a[stop_clock_pkg::CPU_CLOCK_SOURCE_SELECT_POS]
                                     && (state_reg != WAKE || sub_before_stop_reg);
    assign cpu_main_div8           = !cpu_on_sub_clock
                                     && clock_control_reg_a[stop_clock_pkg::DIVIDE_BY_EIGHT_SELECT_POS];
    assign wake_irq                = wake_irq_reg;
    assign bus_hold_levels         = stopped && (processor_mode_reg_a[1:0] != stop_clock_pkg::SINGLE_CHIP_MODE);
    assign bus_strobes_high        = bus_hold_levels;
    assign clock_output_pin        = clock_output_pin_reg;
    assign port9_direction         = port9_direction_reg;
    assign serial3_control         = serial3_control_reg;
    assign serial4_control         = serial4_control_reg;
    assign peripheral_clock_select = peripheral_clock_select_reg;
endmodule : stop_mode_clock_protect

// ==== testbench/stop_clock_chk.sv ====
// concurrent checks on the ports of the stop-mode / clock-protect block
// assumes one core_clk domain and a synchronous active-high srst
module stop_clock_chk (
    input wire logic       core_clk,
    input wire logic       srst,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       nmi_req,
    input wire logic       key_int_req,
    input wire logic       ext_pin_int_req,
    input wire logic       timer_event_int_req,
    input wire logic       serial_ext_clk_int_req,
    input wire logic       periph_int_enabled,
    input wire logic       expansion_crystal_osc_on,
    input wire logic       expansion_osc_on_b,
    input wire logic       expansion_osc_on_c,
    input wire logic       clock_output_pin_div_in,
    input wire logic       main_osc_enable,
    input wire logic       sub_osc_enable,
    input wire logic       expansion_osc_enable,
    input wire logic       cpu_clock_enable,
    input wire logic       periph_clock_enable,
    input wire logic       ext_periph_clock_enable,
    input wire logic       wake_irq,
    input wire logic       stopped,
    input wire logic       bus_hold_levels,
    input wire logic       bus_strobes_high,
    input wire logic       clock_output_pin,
    input wire logic [7:0] port9_direction
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    logic any_wake;
    logic gated_wake;
    // nmi, key and pin requests always wake; externally clocked peripherals only when enabled
    assign any_wake   = nmi_req | key_int_req | ext_pin_int_req;
    assign gated_wake = periph_int_enabled & (timer_event_int_req | serial_ext_clk_int_req);
    sequence stop_exit_s;
        $fell(stopped);
    endsequence
    sequence clocks_back_s;
        cpu_clock_enable && !stopped;
    endsequence
    stop_gates_a: assert property (
        stopped |-> !cpu_clock_enable && !periph_clock_enable && !main_osc_enable && !sub_osc_enable)
        else $error("clocks running while stopped");
    ext_clock_a: assert property (ext_periph_clock_enable)
        else $error("external peripheral clock gated");
    exp_osc_a: assert property (
        expansion_osc_enable == (!stopped || expansion_crystal_osc_on || expansion_osc_on_b || expansion_osc_on_c))
        else $error("expansion oscillator enable wrong");
    stop_entry_a: assert property (
        $rose(stopped) |-> $past(reg_wr) && $past(reg_addr) == stop_clock_pkg::CLOCK_CONTROL_REG_B_IDX)
        else $error("stop entered without control write");
    wake_taken_a: assert property (stopped && (any_wake || gated_wake) |=> !stopped)
        else $error("wake request ignored");
    wake_refused_a: assert property (stopped && !any_wake && !gated_wake |=> stopped)
        else $error("stop left without wake source");
    wake_seq_a: assert property (
        stop_exit_s |-> !cpu_clock_enable [*7] ##[1:3] clocks_back_s ##[0:2] wake_irq)
        else $error("wake sequence timing wrong");
    irq_pulse_a: assert property (wake_irq |-> clocks_back_s ##1 !wake_irq)
        else $error("handler request not a single pulse in run");
    bus_pins_a: assert property (bus_strobes_high |-> stopped && bus_hold_levels)
        else $error("bus pin state outside stop");
    clock_output_pin_run_a: assert property (
        !stopped && !$past(stopped) |-> clock_output_pin == $past(clock_output_pin_div_in))
        else $error("clock output not forwarded");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    port_guard_a: assert property (
        $changed(port9_direction) |-> $past(srst)
            || ($past(reg_wr) && $past(reg_addr) == stop_clock_pkg::PORT9_DIRECTION_REG_IDX))
        else $error("port direction changed without write");
    wake_c: cover property (stop_exit_s);
endmodule : stop_clock_chk

bind stop_mode_clock_protect stop_clock_chk u_stop_clock_chk (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .nmi_req(nmi_req), .key_int_req(key_int_req), .ext_pin_int_req(ext_pin_int_req),
    .timer_event_int_req(timer_event_int_req), .serial_ext_clk_int_req(serial_ext_clk_int_req),
    .periph_int_enabled(periph_int_enabled), .expansion_crystal_osc_on(expansion_crystal_osc_on),
    .expansion_osc_on_b(expansion_osc_on_b), .expansion_osc_on_c(expansion_osc_on_c),
    .clock_output_pin_div_in(clock_output_pin_div_in), .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
    .expansion_osc_enable(expansion_osc_enable), .cpu_clock_enable(cpu_clock_enable),
    .periph_clock_enable(periph_clock_enable), .ext_periph_clock_enable(ext_periph_clock_enable),
    .wake_irq(wake_irq), .stopped(stopped), .bus_hold_levels(bus_hold_levels),
    .bus_strobes_high(bus_strobes_high), .clock_output_pin(clock_output_pin), .port9_direction(port9_direction)
);

// ==== testbench/stop_mode_clock_protect_tb_top.sv ====
// self-checking bench for the stop-mode / clock-protect block
// assumes the design package and the checker are compiled first; the bench drives every port
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module stop_mode_clock_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [3:0] wa; logic [7:0] wd; logic [3:0] ra; logic [7:0] ex; } row_t;
    int          err_total = 0;
    int          compares  = 0;
    logic        core_clk, srst, reg_wr, reg_rd, clock_output_pin_div_in, periph_int_enabled;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [4:0]  src;
    logic [2:0]  exp_on;
    logic        main_osc_enable, sub_osc_enable, expansion_osc_enable, cpu_clock_enable;
    logic        periph_clock_enable, ext_periph_clock_enable, cpu_on_sub_clock, cpu_main_div8;
    logic        wake_irq, stopped, bus_hold_levels, bus_strobes_high, clock_output_pin;
    logic [7:0]  port9_direction, serial3_control, serial4_control, peripheral_clock_select;
    // write, read-back index, expected value; protection is walked in order
    row_t        rows [17] = '{
        '{4'h2, 8'h5a, 4'h2, 8'h00}, '{4'h6, 8'h01, 4'h6, 8'h01}, '{4'h2, 8'h5a, 4'h2, 8'h5a},
        '{4'h7, 8'h11, 4'h6, 8'h01}, '{4'h6, 8'h07, 4'h7, 8'h00}, '{4'h7, 8'h33, 4'h6, 8'h03},
        '{4'h7, 8'h44, 4'h7, 8'h33}, '{4'h6, 8'h07, 4'h6, 8'h07}, '{4'hf, 8'h00, 4'h6, 8'h03},
        '{4'h8, 8'h0c, 4'h8, 8'h00}, '{4'h3, 8'h01, 4'h3, 8'h01}, '{4'h5, 8'h02, 4'h5, 8'h02},
        '{4'h0, 8'hff, 4'h0, 8'h5b}, '{4'h1, 8'h23, 4'h1, 8'h20}, '{4'h5, 8'h00, 4'h5, 8'h00},
        '{4'h1, 8'h00, 4'h1, 8'h00}, '{4'h0, 8'h01, 4'h0, 8'h01}};

    stop_mode_clock_protect u_stop_mode_clock_protect (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_req(src[0]), .key_int_req(src[1]),
        .ext_pin_int_req(src[2]), .timer_event_int_req(src[3]), .serial_ext_clk_int_req(src[4]),
        .periph_int_enabled(periph_int_enabled), .expansion_crystal_osc_on(exp_on[0]),
        .expansion_osc_on_b(exp_on[1]), .expansion_osc_on_c(exp_on[2]), .clock_output_pin_div_in(clock_output_pin_div_in),
        .main_osc_enable(main_osc_enable), .sub_osc_enable(sub_osc_enable),
        .expansion_osc_enable(expansion_osc_enable), .cpu_clock_enable(cpu_clock_enable),
        .periph_clock_enable(periph_clock_enable), .ext_periph_clock_enable(ext_periph_clock_enable),
        .cpu_on_sub_clock(cpu_on_sub_clock), .cpu_main_div8(cpu_main_div8), .wake_irq(wake_irq),
        .stopped(stopped), .bus_hold_levels(bus_hold_levels), .bus_strobes_high(bus_strobes_high),
        .clock_output_pin(clock_output_pin), .port9_direction(port9_direction),
        .serial3_control(serial3_control), .serial4_control(serial4_control),
        .peripheral_clock_select(peripheral_clock_select));

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // enter stop with a given clock setup, try refused sources, then wake by one source
    task automatic stop_wake(input logic [4:0] s, input logic [7:0] cca_v, input logic [2:0] e);
        int   n;
        logic pin_before;
        @(posedge core_clk);
        clock_output_pin_div_in <= (cca_v[1:0] != 2'h1);
        exp_on        <= e;
        wr(4'h0, cca_v);
        wr(4'h1, 8'h00);
        wr(4'h1, 8'h01);
        #1;
        pin_before = clock_output_pin;
        `CHK(stopped, 1'b1)
        `CHK({cpu_clock_enable, periph_clock_enable, main_osc_enable, sub_osc_enable}, 4'h0)
        `CHK(ext_periph_clock_enable, 1'b1)
        `CHK(expansion_osc_enable, |e)
        `CHK({bus_hold_levels, bus_strobes_high}, 2'b11)
        @(posedge core_clk);
        clock_output_pin_div_in <= ~clock_output_pin_div_in;
        src           <= 5'h18;
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(stopped, 1'b1)
        `CHK(clock_output_pin, (cca_v[1:0] == 2'h1) ? 1'b1 : pin_before)
        @(posedge core_clk);
        src                <= s;
        periph_int_enabled <= |s[4:3];
        n = 0;
        while (wake_irq !== 1'b1 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 40)
        begin
            err_total++;
            test_done();
        end
        `CHK(cpu_clock_enable, 1'b1)
        `CHK(cpu_on_sub_clock, cca_v[7])
        if (!cca_v[7])
            `CHK(cpu_main_div8, 1'b1)
        @(posedge core_clk);
        src                <= 5'h00;
        periph_int_enabled <= 1'b0;
        rd(4'h0, d);
        `CHK(d, cca_v | 8'h40)
        rd(4'h1, d);
        `CHK(d, 8'h20)
        $display("stop test done source %h", s);
    endtask : stop_wake

    initial
    begin
        srst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        src = 5'h00;
        exp_on = 3'h0;
        periph_int_enabled = 1'b0;
        clock_output_pin_div_in = 1'b0;
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        `CHK({cpu_clock_enable, wake_irq, stopped, reg_rdata}, 11'h400)
        for (int i = 0; i < 11; i++)
        begin
            rd(4'(i), d);
            `CHK(d, (i == 0) ? 8'h48 : (i == 1) ? 8'h20 : 8'h00)
        end
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, d);
            `CHK(d, rows[i].ex)
        end
        `CHK({peripheral_clock_select, port9_direction, serial3_control, serial4_control}, 32'h5a33_0000)
        $display("protect test done");
        for (int i = 0; i < 5; i++)
            stop_wake(5'h01 << i, 8'h01, 3'(i));
        stop_wake(5'h01, 8'h82, 3'h4);
        // hardware reset is the one exit that needs no wake source
        wr(4'h1, 8'h01);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        `CHK({stopped, cpu_clock_enable, cpu_main_div8}, 3'h3)
        $display("reset exit test done");
        test_done();
    end
endmodule : stop_mode_clock_protect_tb_top
